// ---- hw/bit_unit_pkg.sv ----
// constants, commands and carriers for the increment, loop and bit unit
// assumes a single core clock and a sequencer that issues one op at a time
package bit_unit_pkg;
   localparam logic [7:0] BYTE_ONE       = 8'h01;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam logic [7:0] USER_BIT_BASE  = 8'h20;
   localparam int         SFR_BIT_FLAG   = 7;
   localparam int         BIT_POS_W      = 3;
   localparam int         ACC_SEL_IDX    = 8;
   localparam logic [7:0] TIMER_CTRL_ADR = 8'h88;
   localparam int         TIMER1_RUN_POS = 6;
   localparam logic [7:0] PORT0_ADR      = 8'h80;

   // operation codes issued by the sequencer
   typedef enum logic [3:0] {
      OP_NONE,
      OP_INCREMENT,
      OP_DECREMENT,
      OP_DEC_BRANCH_NZ,
      OP_BIT_SET,
      OP_BIT_CLEAR,
      OP_BIT_COMPLEMENT,
      OP_CARRY_SET,
      OP_CARRY_CLEAR,
      OP_CARRY_COMPLEMENT,
      OP_ACC_CLEAR,
      OP_ACC_INVERT,
      OP_MOVE_BIT_TO_CARRY,
      OP_MOVE_CARRY_TO_BIT
   } op_e;

   // operand location for byte operations
   typedef enum logic [1:0] {
      LOC_ACC,
      LOC_WORK_REG,
      LOC_DIRECT
   } loc_e;

   // request from the sequencer
   typedef struct packed {
      op_e        op;
      loc_e       loc;
      logic [7:0] addr;   // byte address, or bit address for bit ops
   } req_s;

   // one byte write toward ram or sfr space
   typedef struct packed {
      logic       en;
      logic       is_sfr;
      logic [7:0] addr;
      logic [7:0] data;
   } wr_s;
endpackage

// ---- hw/bit_addr_decode.sv ----
// bit address decoder: maps a bit number onto a byte address and position
// assumes bit numbers below 0x80 are ram user bits, the rest sfr bits
module bit_addr_decode
   import bit_unit_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // bit address in
   input  wire logic [7:0]           bit_addr,
   // decoded location, registered
   output logic                      is_sfr_q,
   output logic [7:0]                byte_addr_q,
   output logic [BIT_POS_W-1:0]      bit_pos_q
);
   // registered so the byte read can be issued from a stable address
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         is_sfr_q    <= 1'b0;
         byte_addr_q <= BYTE_ZERO;
         bit_pos_q   <= '0;
      end else begin
         is_sfr_q  <= bit_addr[SFR_BIT_FLAG];
         bit_pos_q <= bit_addr[BIT_POS_W-1:0];
         if (bit_addr[SFR_BIT_FLAG]) begin
            // sfr whose address is divisible by eight
            byte_addr_q <= {bit_addr[7:BIT_POS_W], {BIT_POS_W{1'b0}}};
         end else begin
            // user bit n lives in byte 0x20 + n/8
            byte_addr_q <= USER_BIT_BASE
                         + {4'h0, bit_addr[6:BIT_POS_W]};
         end
      end
   end
endmodule

// ---- hw/inc_dec_loop_bit_ops_unit.sv ----
// execution datapath for increment, decrement, loop and bit operations
// assumes a sequencer issuing one request when idle and memory that
// answers a byte read one cycle after the read strobe
//
// Overview of operation
// - increment adds one to the byte, 255 wraps to zero.
// - decrement subtracts one, zero wraps to 255.
// - increment and decrement leave every flag, carry included, untouched.
// - byte ops work on accumulator, working registers and direct addresses.
// - loop op decrements its register, branches if the new value nonzero.
// - loop body runs as many times as the initial counter value, 256 times for zero.
// - bits 0x00-0x7F map to ram bytes 0x20-0x2F, bit n mod 8.
// - bits 0x80-0xFF select bits of sfrs at addresses divisible by eight.
// - bit 0x80 is bit 0 of the first port latch at 0x80.
// - bit set writes one to a user bit or an sfr bit, never to carry.
// - bit clear writes zero using the same addressing.
// - bit complement inverts the addressed bit.
// - carry set is its own op with no bit address.
// - accumulator clear loads zero into all eight bits.
// - accumulator invert flips all eight bits.
// - bit moves only between carry and an addressable bit.
// - timer1 run bit is bit 6 of timer control at 0x88.
module inc_dec_loop_bit_ops_unit
   import bit_unit_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // request from sequencer
   input  wire logic        req_valid,
   input  wire req_s        req,
   output logic             busy_q,
   output logic             done_q,
   output logic             branch_taken_q,
   // working register and accumulator values from the register file
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  work_reg_in,
   // byte read port toward ram and sfr space
   output logic             rd_en_q,
   output logic             rd_is_sfr_q,
   output logic [7:0]       rd_addr_q,
   input  wire logic [7:0]  rd_data,
   // byte write port toward ram and sfr space
   output wr_s              wr_q,
   // register file write backs
   output logic             acc_wr_q,
   output logic [7:0]       acc_wdata_q,
   output logic             work_reg_wr_q,
   output logic [7:0]       work_reg_wdata_q,
   // carry flag, held here
   output logic             carry_q,
   // timer1 run level as last written through the bit or direct byte path
   output logic             timer1_run_q
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DECODE,
      ST_READ,
      ST_WAIT,
      ST_WRITE
   } state_e;

   state_e               state_q;
   req_s                 req_q;
   logic                 is_sfr;
   logic [7:0]           byte_addr;
   logic [BIT_POS_W-1:0] bit_pos;
   logic [7:0]           src_byte;
   logic [7:0]           new_byte;
   logic                 old_bit;
   logic                 new_bit;
   logic                 is_bit_op;
   logic                 is_byte_op;
   logic                 bit_to_carry;

   bit_addr_decode u_decode (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .bit_addr    (req_q.addr),
      .is_sfr_q    (is_sfr),
      .byte_addr_q (byte_addr),
      .bit_pos_q   (bit_pos)
   );

   // operation classes
   assign is_byte_op = (req_q.op == OP_INCREMENT)
                     || (req_q.op == OP_DECREMENT)
                     || (req_q.op == OP_DEC_BRANCH_NZ);
   assign is_bit_op  = (req_q.op == OP_BIT_SET)
                     || (req_q.op == OP_BIT_CLEAR)
                     || (req_q.op == OP_BIT_COMPLEMENT)
                     || (req_q.op == OP_MOVE_BIT_TO_CARRY)
                     || (req_q.op == OP_MOVE_CARRY_TO_BIT);
   // a bit move has carry on one side always, never bit to bit
   assign bit_to_carry = (req_q.op == OP_MOVE_BIT_TO_CARRY);

   // operand byte for byte ops
   always_comb begin
      case (req_q.loc)
         LOC_ACC:      src_byte = acc_in;
         LOC_WORK_REG: src_byte = work_reg_in;
         default:      src_byte = rd_data;
      endcase
   end

   // new byte value, wraps naturally at eight bits
   always_comb begin
      new_byte = src_byte;
      old_bit  = rd_data[bit_pos];
      new_bit  = old_bit;
      case (req_q.op)
         OP_INCREMENT:         new_byte = src_byte + BYTE_ONE;
         OP_DECREMENT:         new_byte = src_byte - BYTE_ONE;
         OP_DEC_BRANCH_NZ:     new_byte = src_byte - BYTE_ONE;
         OP_BIT_SET:           new_bit  = 1'b1;
         OP_BIT_CLEAR:         new_bit  = 1'b0;
         OP_BIT_COMPLEMENT:    new_bit  = ~old_bit;
         OP_MOVE_CARRY_TO_BIT: new_bit  = carry_q;
         default:              new_bit  = old_bit;
      endcase
      if (is_bit_op) begin
         // read-modify-write keeps the other seven bits
         new_byte          = rd_data;
         new_byte[bit_pos] = new_bit;
      end
   end

   // sequencer state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_IDLE;
         req_q   <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  req_q   <= req;
                  state_q <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               // direct bytes and bits need memory; others finish now
               if (is_bit_op || (is_byte_op && req_q.loc == LOC_DIRECT)) begin
                  state_q <= ST_READ;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_READ:  state_q <= ST_WAIT;
            ST_WAIT:  state_q <= ST_WRITE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   // busy and done strobes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         busy_q <= (state_q == ST_IDLE) ? req_valid : 1'b1;
         done_q <= 1'b0;
         if (state_q == ST_WRITE) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end else if (state_q == ST_DECODE
                      && !(is_bit_op
                      || (is_byte_op && req_q.loc == LOC_DIRECT))) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end
      end
   end

   // byte read strobe, one cycle wide
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_en_q     <= 1'b0;
         rd_is_sfr_q <= 1'b0;
         rd_addr_q   <= BYTE_ZERO;
      end else begin
         rd_en_q <= 1'b0;
         if (state_q == ST_READ) begin
            rd_en_q <= 1'b1;
            if (is_bit_op) begin
               rd_is_sfr_q <= is_sfr;
               rd_addr_q   <= byte_addr;
            end else begin
               // direct byte: upper half is sfr space
               rd_is_sfr_q <= req_q.addr[SFR_BIT_FLAG];
               rd_addr_q   <= req_q.addr;
            end
         end
      end
   end

   // memory write back, skipped when the bit is only copied to carry
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_q <= '0;
      end else begin
         wr_q.en <= 1'b0;
         if (state_q == ST_WRITE && !bit_to_carry) begin
            wr_q.en     <= 1'b1;
            wr_q.is_sfr <= rd_is_sfr_q;
            wr_q.addr   <= rd_addr_q;
            wr_q.data   <= new_byte;
         end
      end
   end

   // accumulator write back
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc_wr_q    <= 1'b0;
         acc_wdata_q <= BYTE_ZERO;
      end else begin
         acc_wr_q <= 1'b0;
         if (state_q == ST_DECODE) begin
            if (req_q.op == OP_ACC_CLEAR) begin
               acc_wr_q    <= 1'b1;
               acc_wdata_q <= BYTE_ZERO;
            end else if (req_q.op == OP_ACC_INVERT) begin
               acc_wr_q    <= 1'b1;
               acc_wdata_q <= ~acc_in;
            end else if (is_byte_op && req_q.loc == LOC_ACC) begin
               acc_wr_q    <= 1'b1;
               acc_wdata_q <= new_byte;
            end
         end
      end
   end

   // working register write back and loop branch decision
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         work_reg_wr_q    <= 1'b0;
         work_reg_wdata_q <= BYTE_ZERO;
         branch_taken_q   <= 1'b0;
      end else begin
         work_reg_wr_q <= 1'b0;
         if (state_q == ST_DECODE || state_q == ST_WRITE) begin
            branch_taken_q <= 1'b0;
         end
         if (state_q == ST_DECODE && is_byte_op
             && req_q.loc == LOC_WORK_REG) begin
            work_reg_wr_q    <= 1'b1;
            work_reg_wdata_q <= new_byte;
         end
         // decrement first, then test the new value; zero falls through
         if (req_q.op == OP_DEC_BRANCH_NZ
             && ((state_q == ST_DECODE && req_q.loc != LOC_DIRECT)
             || state_q == ST_WRITE)) begin
            branch_taken_q <= (new_byte != BYTE_ZERO);
         end
      end
   end

   // carry flag; byte ops never reach it, wrap or not
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         carry_q <= 1'b0;
      end else if (state_q == ST_DECODE) begin
         case (req_q.op)
            OP_CARRY_SET:        carry_q <= 1'b1;
            OP_CARRY_CLEAR:      carry_q <= 1'b0;
            OP_CARRY_COMPLEMENT: carry_q <= ~carry_q;
            default:             carry_q <= carry_q;
         endcase
      end else if (state_q == ST_WRITE && bit_to_carry) begin
         carry_q <= old_bit;
      end
   end

   // timer1 run tracks writes landing on the timer control byte
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer1_run_q <= 1'b0;
      end else if (state_q == ST_WRITE && !bit_to_carry && rd_is_sfr_q
                   && rd_addr_q == TIMER_CTRL_ADR) begin
         timer1_run_q <= new_byte[TIMER1_RUN_POS];
      end
   end
endmodule

// ---- sim/inc_dec_loop_bit_ops_chk.sv ----
// assertion checker for the increment, loop and bit unit
// assumes it is bound to the unit top and sees only its ports
module inc_dec_loop_bit_ops_chk
   import bit_unit_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // request side
   input wire logic       req_valid,
   input wire req_s       req,
   input wire logic       busy_q,
   input wire logic       done_q,
   input wire logic       branch_taken_q,
   // register file side
   input wire logic [7:0] acc_in,
   input wire logic [7:0] work_reg_in,
   input wire logic       acc_wr_q,
   input wire logic [7:0] acc_wdata_q,
   input wire logic       work_reg_wr_q,
   input wire logic [7:0] work_reg_wdata_q,
   // memory side
   input wire logic       rd_en_q,
   input wire logic       rd_is_sfr_q,
   input wire logic [7:0] rd_addr_q,
   input wire logic [7:0] rd_data,
   input wire wr_s        wr_q,
   // flags
   input wire logic       carry_q,
   input wire logic       timer1_run_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // a request counts only while idle, as the sequencer sees it
   logic take;
   assign take = req_valid && !busy_q;
   a_inc_acc_wrap: assert property (take && req.op == OP_INCREMENT &&
      req.loc == LOC_ACC |-> ##2 acc_wr_q && acc_wdata_q ==
      $past(acc_in, 2) + 8'h01) else $error("acc increment wrong");
   a_dec_acc_wrap: assert property (take && req.op == OP_DECREMENT &&
      req.loc == LOC_ACC |-> ##2 acc_wr_q && acc_wdata_q ==
      $past(acc_in, 2) - 8'h01) else $error("acc decrement wrong");
   a_carry_kept_incdec: assert property (take &&
      (req.op == OP_INCREMENT || req.op == OP_DECREMENT)
      |=> $stable(carry_q) [*2]) else $error("carry moved by inc or dec");
   a_loop_branch_test: assert property (take &&
      req.op == OP_DEC_BRANCH_NZ && req.loc == LOC_WORK_REG
      |-> ##2 work_reg_wr_q && done_q &&
      work_reg_wdata_q == $past(work_reg_in, 2) - 8'h01 &&
      branch_taken_q == (work_reg_wdata_q != 8'h00))
      else $error("loop decrement or branch wrong");
   a_acc_clear_zero: assert property (take && req.op == OP_ACC_CLEAR
      |-> ##2 acc_wr_q && acc_wdata_q == 8'h00) else $error("acc not clear");
   a_acc_invert_all: assert property (take &&
      req.op == OP_ACC_INVERT |-> ##2 acc_wr_q &&
      acc_wdata_q == ~$past(acc_in, 2)) else $error("acc not inverted");
   a_read_space_sel: assert property (rd_en_q |->
      rd_is_sfr_q == rd_addr_q[7] ##1 !rd_en_q) else $error("read space wrong");
   a_bit_set_rmw: assert property (take && req.op == OP_BIT_SET
      |-> ##5 wr_q.en && done_q && wr_q.data ==
      (rd_data | (8'h01 << $past(req.addr[2:0], 5))))
      else $error("bit set write data wrong");
   a_timer_run_follow: assert property (wr_q.en && wr_q.is_sfr &&
      wr_q.addr == TIMER_CTRL_ADR |-> ##1 timer1_run_q ==
      $past(wr_q.data[TIMER1_RUN_POS])) else $error("timer1 run not updated");
endmodule

bind inc_dec_loop_bit_ops_unit inc_dec_loop_bit_ops_chk u_chk (
   .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
   .busy_q(busy_q), .done_q(done_q), .branch_taken_q(branch_taken_q),
   .acc_in(acc_in), .work_reg_in(work_reg_in), .acc_wr_q(acc_wr_q),
   .acc_wdata_q(acc_wdata_q), .work_reg_wr_q(work_reg_wr_q),
   .work_reg_wdata_q(work_reg_wdata_q), .rd_en_q(rd_en_q),
   .rd_is_sfr_q(rd_is_sfr_q), .rd_addr_q(rd_addr_q), .rd_data(rd_data),
   .wr_q(wr_q), .carry_q(carry_q), .timer1_run_q(timer1_run_q));

// ---- sim/inc_dec_loop_bit_ops_unit_tb.sv ----
// self-checking bench for the increment, loop and bit unit
// assumes the checker is bound in; memory answers from a local array
module inc_dec_loop_bit_ops_unit_tb;
   import bit_unit_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys, rst, req_valid, busy_q, done_q, branch_taken_q;
   logic       rd_en_q, rd_is_sfr_q, acc_wr_q, work_reg_wr_q, carry_q;
   logic       timer1_run_q, s_br;
   logic [7:0] acc_in, work_reg_in, rd_addr_q, rd_data, acc_wdata_q;
   logic [7:0] work_reg_wdata_q, s_acc, s_wrd;
   logic [7:0] mem [0:511];
   req_s       req;
   wr_s        wr_q;
   int         err_count = 0;
   int         compares = 0;
   int         cyc = 0;

   inc_dec_loop_bit_ops_unit u_inc_dec_loop_bit_ops_unit (
      .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
      .busy_q(busy_q), .done_q(done_q), .branch_taken_q(branch_taken_q),
      .acc_in(acc_in), .work_reg_in(work_reg_in), .rd_en_q(rd_en_q),
      .rd_is_sfr_q(rd_is_sfr_q), .rd_addr_q(rd_addr_q), .rd_data(rd_data),
      .wr_q(wr_q), .acc_wr_q(acc_wr_q), .acc_wdata_q(acc_wdata_q),
      .work_reg_wr_q(work_reg_wr_q), .work_reg_wdata_q(work_reg_wdata_q),
      .carry_q(carry_q), .timer1_run_q(timer1_run_q));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ram and sfr byte store; read data lands a cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_en_q) rd_data <= #1 mem[{rd_is_sfr_q, rd_addr_q}];
      if (wr_q.en) mem[{wr_q.is_sfr, wr_q.addr}] <= wr_q.data;
   end
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   // byte holding a bit: user bits in ram from 0x20, sfr bits by address
   function automatic logic [8:0] loc_of(input logic [7:0] b);
      return b[7] ? {1'b1, b & 8'hF8} : {1'b0, USER_BIT_BASE + {4'h0, b[6:3]}};
   endfunction
   // one request, held for its take edge, then a bounded wait for done
   task automatic run(input op_e op, input loc_e loc, input logic [7:0] a);
      int n;
      n = 0;
      req = '{op, loc, a};
      req_valid = 1'b1;
      @(posedge clk_sys);
      #1 req_valid = 1'b0;
      chk1("busy", 1'b1, busy_q);
      while (done_q !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1 n++;
      end
      chk1("done", 1'b1, done_q);
      chk1("idle", 1'b0, busy_q);
      s_acc = acc_wdata_q;
      s_wrd = work_reg_wdata_q;
      s_br = branch_taken_q;
      // the byte store takes the write at the edge after done
      @(posedge clk_sys);
      #1;
   endtask
   task automatic bit_step(input op_e op, input logic [7:0] b, e);
      run(op, LOC_DIRECT, b);
      chk8("bit byte", e, mem[loc_of(b)]);
   endtask

   task automatic t_byte();
      acc_in = 8'hFF;
      run(OP_CARRY_SET, LOC_ACC, 8'h00);
      chk1("carry", 1'b1, carry_q);
      run(OP_INCREMENT, LOC_ACC, 8'h00);
      chk8("acc inc", 8'h00, s_acc);
      chk1("carry", 1'b1, carry_q);
      acc_in = 8'h00;
      run(OP_DECREMENT, LOC_ACC, 8'h00);
      chk8("acc dec", 8'hFF, s_acc);
      run(OP_CARRY_CLEAR, LOC_ACC, 8'h00);
      chk1("carry", 1'b0, carry_q);
      run(OP_DECREMENT, LOC_ACC, 8'h00);
      chk1("carry", 1'b0, carry_q);
      run(OP_CARRY_COMPLEMENT, LOC_ACC, 8'h00);
      chk1("carry", 1'b1, carry_q);
      work_reg_in = 8'h7F;
      run(OP_INCREMENT, LOC_WORK_REG, 8'h00);
      chk8("work inc", 8'h80, s_wrd);
      mem[9'h040] = 8'hFF;
      run(OP_INCREMENT, LOC_DIRECT, 8'h40);
      chk8("ram inc", 8'h00, mem[9'h040]);
      mem[9'h1A0] = 8'h00;
      run(OP_DECREMENT, LOC_DIRECT, 8'hA0);
      chk8("sfr dec", 8'hFF, mem[9'h1A0]);
      chk1("carry", 1'b1, carry_q);
   endtask
   task automatic t_loop();
      int cnt;
      cnt = 0;
      work_reg_in = 8'h08;
      do begin
         cnt++;
         run(OP_DEC_BRANCH_NZ, LOC_WORK_REG, 8'h00);
         work_reg_in = s_wrd;
      end while (s_br === 1'b1 && cnt < 20);
      chk8("loop passes", 8'h08, 8'(cnt));
      chk8("loop final", 8'h00, s_wrd);
   endtask
   task automatic t_acc();
      acc_in = 8'hFF;
      run(OP_ACC_INVERT, LOC_ACC, 8'h00);
      chk8("acc invert", 8'h00, s_acc);
      acc_in = 8'h3C;
      run(OP_ACC_INVERT, LOC_ACC, 8'h00);
      chk8("acc invert", 8'hC3, s_acc);
      run(OP_ACC_CLEAR, LOC_ACC, 8'h00);
      chk8("acc clear", 8'h00, s_acc);
   endtask
   task automatic t_bits();
      logic [7:0] bits [6] = '{8'h00, 8'h7F, 8'h20, 8'h80, 8'h8E, 8'hF7};
      logic [7:0] m, p;
      foreach (bits[i]) begin
         m = 8'h01 << bits[i][2:0];
         p = 8'h5A & ~m;
         mem[loc_of(bits[i])] = p;
         bit_step(OP_BIT_SET, bits[i], p | m);
         if (bits[i] == 8'h8E) chk1("run", 1'b1, timer1_run_q);
         bit_step(OP_BIT_COMPLEMENT, bits[i], p);
         bit_step(OP_BIT_COMPLEMENT, bits[i], p | m);
         bit_step(OP_BIT_CLEAR, bits[i], p);
         if (bits[i] == 8'h8E) chk1("run", 1'b0, timer1_run_q);
         run(OP_CARRY_SET, LOC_ACC, 8'h00);
         bit_step(OP_MOVE_CARRY_TO_BIT, bits[i], p | m);
         run(OP_CARRY_CLEAR, LOC_ACC, 8'h00);
         bit_step(OP_MOVE_BIT_TO_CARRY, bits[i], p | m);
         chk1("carry", 1'b1, carry_q);
      end
   endtask

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      acc_in = 8'h00;
      work_reg_in = 8'h00;
      rd_data = 8'h00;
      repeat (20) @(posedge clk_sys);
      #1 rst = 1'b0;
      t_byte();
      t_loop();
      t_acc();
      t_bits();
      end_of_test();
   end
endmodule
